/* File: verilog/ccod_pkg.sv */
// Constants and types for the processor-control opcode decoder.
// Assumes a single core clock and byte-wide instruction fetch.
package ccod_pkg;

  // Opcodes handled by the decoder.
  localparam logic [7:0] OP_INT_TYPED = 8'hcd;
  localparam logic [7:0] OP_INT3 = 8'hcc;
  localparam logic [7:0] OP_OVF_TRAP = 8'hce;
  localparam logic [7:0] OP_HANDLER_RET = 8'hcf;
  localparam logic [7:0] OP_RANGE_CHECK = 8'h62;
  localparam logic [7:0] OP_CARRY_CLR = 8'hf8;
  localparam logic [7:0] OP_CARRY_SET = 8'hf9;
  localparam logic [7:0] OP_CARRY_INV = 8'hf5;
  localparam logic [7:0] OP_DIR_CLR = 8'hfc;
  localparam logic [7:0] OP_DIR_SET = 8'hfd;
  localparam logic [7:0] OP_IE_CLR = 8'hfa;
  localparam logic [7:0] OP_IE_SET = 8'hfb;
  localparam logic [7:0] OP_HALT = 8'hf4;
  localparam logic [7:0] OP_WAIT = 8'h9b;
  localparam logic [7:0] OP_LOCK = 8'hf0;
  localparam logic [7:0] OP_NOP = 8'h90;
  localparam logic [4:0] OP_HANDOFF_TOP = 5'h1b;
  localparam logic [2:0] OP_SEG_OVR_TOP = 3'h1;
  localparam logic [2:0] OP_SEG_OVR_LOW = 3'h6;

  // Addressing byte fields.
  localparam logic [1:0] MODE_NO_DISP = 2'h0;
  localparam logic [1:0] MODE_DISP8 = 2'h1;
  localparam logic [1:0] MODE_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [2:0] RM_BP_SI = 3'h2;
  localparam logic [2:0] RM_BP_DI = 3'h3;

  // Segment select codes.
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // Interrupt types raised by the decoder.
  localparam logic [7:0] INT_TYPE_BREAK = 8'h03;
  localparam logic [7:0] INT_TYPE_OVF = 8'h04;

  // Cycle counts, byte operand figures.
  localparam logic [7:0] CYC_INT_TYPED = 8'h2f;
  localparam logic [7:0] CYC_INT3 = 8'h2d;
  localparam logic [7:0] CYC_OVF_TAKEN = 8'h30;
  localparam logic [7:0] CYC_OVF_NOT = 8'h04;
  localparam logic [7:0] CYC_HANDLER_RET = 8'h1c;
  localparam logic [7:0] CYC_RANGE_MIN = 8'h21;
  localparam logic [7:0] CYC_RANGE_MAX = 8'h23;
  localparam logic [7:0] CYC_FLAG = 8'h02;
  localparam logic [7:0] CYC_WAIT = 8'h06;
  localparam logic [7:0] CYC_LOCK_W16 = 8'h02;
  localparam logic [7:0] CYC_LOCK_W8 = 8'h03;
  localparam logic [7:0] CYC_HANDOFF = 8'h06;
  localparam logic [7:0] CYC_NOP = 8'h03;
  localparam logic [7:0] CYC_WORD_XFER = 8'h04;
  localparam logic [7:0] CYC_OFFSET_CALC = 8'h04;

  // Reset values of the flags.
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_IE = 1'b0;

  // General register selection: word registers, then byte registers.
  typedef enum logic [3:0] {
    GPR_AX, GPR_CX, GPR_DX, GPR_BX, GPR_SP, GPR_BP, GPR_SI, GPR_DI,
    GPR_AL, GPR_CL, GPR_DL, GPR_BL, GPR_AH, GPR_CH, GPR_DH, GPR_BH
  } ccod_gpr_t;

  // Maps the register field and width to a register.
  function automatic ccod_gpr_t reg_index(input logic word,
                                          input logic [2:0] code);
    reg_index = ccod_gpr_t'({~word, code});
  endfunction

  // Adds the word surcharge for each memory transfer.
  function automatic logic [7:0] cyc_adj(input logic [7:0] base,
                                         input logic word,
                                         input logic [1:0] xfers);
    cyc_adj = word ? 8'(base + CYC_WORD_XFER * {6'h00, xfers}) : base;
  endfunction

endpackage

/* File: verilog/ccod_modrm_if.sv */
// Carrier for the addressing byte and its decoded fields.
// Assumes the decoder core drives the byte and reads the fields.
`timescale 1ns/100ps
interface ccod_modrm_if;
  logic [7:0] modrm;
  logic [1:0] mode;
  logic [2:0] reg_code;
  logic [2:0] rm;
  logic [1:0] disp_bytes;
  logic direct;
  logic uses_frame_base;

  modport dec
  (
    input modrm,
    output mode, reg_code, rm, disp_bytes, direct, uses_frame_base
  );
  modport core
  (
    output modrm,
    input mode, reg_code, rm, disp_bytes, direct, uses_frame_base
  );
endinterface

/* File: verilog/ccod_modrm_dec.sv */
// Field decoder for the addressing byte.
// Assumes the byte on the carrier is stable within the cycle.
`timescale 1ns/100ps
module ccod_modrm_dec
(
  // Addressing byte and decoded fields.
  ccod_modrm_if.dec mr
);

  // Splits the byte and works out the displacement length.
  always_comb
  begin
    mr.mode = mr.modrm[7:6];
    mr.reg_code = mr.modrm[5:3];
    mr.rm = mr.modrm[2:0];
    mr.direct = (mr.modrm[7:6] == ccod_pkg::MODE_NO_DISP) &&
                (mr.modrm[2:0] == ccod_pkg::RM_DIRECT);
    if (mr.direct)
      mr.disp_bytes = 2'h2;
    else if (mr.modrm[7:6] == ccod_pkg::MODE_DISP8)
      mr.disp_bytes = 2'h1;
    else if (mr.modrm[7:6] == ccod_pkg::MODE_REG ||
             mr.modrm[7:6] == ccod_pkg::MODE_NO_DISP)
      mr.disp_bytes = 2'h0;
    else
      mr.disp_bytes = 2'h2;
    // Frame base forms: base plus index, or base alone with displacement.
    mr.uses_frame_base = (mr.modrm[7:6] != ccod_pkg::MODE_REG) &&
      ((mr.modrm[2:0] == ccod_pkg::RM_BP_SI) ||
       (mr.modrm[2:0] == ccod_pkg::RM_BP_DI) ||
       (mr.modrm[2:0] == ccod_pkg::RM_DIRECT && !mr.direct));
  end

endmodule // ccod_modrm_dec

/* File: verilog/ccod_top.sv */
// Processor-control opcode decoder with cycle counting.
// Assumes bytes arrive one per handshake from the prefetch logic and
// that the coprocessor busy level is asynchronous to the core clock.
`timescale 1ns/100ps

// Contract
// - CE traps on overflow, 48 else 4.
// - CF returns from handler in 28.
// - 62 plus addressing byte: range check 33-35.
// - F5 inverts carry in 2 clocks.
// - F0 locks next instruction, 2 or 3.
// - 11011TTT escape to coprocessor, 6 clocks.
// - Word operation adds 4 per transfer.
// - Offset calculation 4 clocks, already included.
// - Mode 00 selector 110 means direct offset.
// - Displacement follows addressing byte, before data.
// - Register field maps word and byte registers.
// - Override codes: extra, code, stack, data.
// - Frame base operands default to stack segment.
// - String destination always extra segment.
module ccod_top
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Instruction byte stream.
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  // Execution context.
  input wire logic i_word_op,
  input wire logic [1:0] i_mem_xfers,
  input wire logic i_bus8,
  input wire logic i_overflow_flag,
  input wire logic i_string_dest,
  input wire logic i_wake,
  // Coprocessor.
  input wire logic i_copro_busy,
  output logic o_copro_valid,
  output logic [5:0] o_copro_opcode,
  // Decode results.
  output logic o_done,
  output logic o_illegal,
  output logic o_busy,
  output logic [7:0] o_cycles,
  output logic o_int_take,
  output logic [7:0] o_int_type,
  output logic o_lock,
  output logic o_halt,
  output logic o_carry,
  output logic o_dir,
  output logic o_ie,
  output logic [1:0] o_seg_sel,
  output logic o_direct,
  output logic [15:0] o_operand_offset,
  output logic [3:0] o_reg_sel
);

  typedef enum logic [2:0] {
    S_IDLE, S_TYPE, S_MODRM, S_DISP_LO, S_DISP_HI, S_WAITC, S_EXEC, S_HALTED
  } ccod_state_t;

  typedef struct packed {
    ccod_state_t st;
    logic ready;
    logic busy;
    logic [7:0] cnt;
    logic [7:0] cycles;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [15:0] disp;
    logic word;
    logic [1:0] xfers;
    logic prefix;
    logic lock;
    logic seg_v;
    logic [1:0] seg_ovr;
    logic [1:0] seg_sel;
    logic direct;
    logic [3:0] reg_sel;
    logic carry;
    logic dir;
    logic ie;
    logic halt;
    logic int_take;
    logic [7:0] int_type;
    logic copro_v;
    logic [5:0] copro_op;
    logic done;
    logic bad;
    logic busy_s1;
    logic busy_s2;
  } ccod_regs_t;

  ccod_regs_t r_reg;
  ccod_regs_t r_next;
  ccod_modrm_if mr ();

  // Field decode of the addressing byte, live while it is being taken.
  ccod_modrm_dec u_modrm
  (
    .mr(mr)
  );
  assign mr.modrm = (r_reg.st == S_MODRM) ? i_byte : r_reg.modrm;

  // Next-state logic of the whole decoder.
  always_comb
  begin
    logic take;
    logic fin;
    logic [7:0] base;
    take = r_reg.ready && i_byte_valid;
    fin = 1'b0;
    base = 8'h00;
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.bad = 1'b0;
    r_next.copro_v = 1'b0;
    r_next.int_take = 1'b0;
    r_next.busy_s1 = i_copro_busy;
    r_next.busy_s2 = r_reg.busy_s1;
    unique case (r_reg.st)
      S_IDLE:
      begin
        if (take)
        begin
          r_next.opcode = i_byte;
          r_next.word = i_word_op;
          r_next.xfers = i_mem_xfers;
          r_next.st = S_EXEC;
          r_next.prefix = 1'b0;
          if (i_byte == ccod_pkg::OP_LOCK)
          begin
            r_next.lock = 1'b1;
            r_next.prefix = 1'b1;
            base = i_bus8 ? ccod_pkg::CYC_LOCK_W8 : ccod_pkg::CYC_LOCK_W16;
          end
          else if (i_byte[7:5] == ccod_pkg::OP_SEG_OVR_TOP &&
                   i_byte[2:0] == ccod_pkg::OP_SEG_OVR_LOW)
          begin
            // Override prefix is free and stays armed for the next opcode.
            r_next.seg_v = 1'b1;
            r_next.seg_ovr = i_byte[4:3];
            r_next.st = S_IDLE;
          end
          else if (i_byte == ccod_pkg::OP_INT_TYPED)
            r_next.st = S_TYPE;
          else if (i_byte == ccod_pkg::OP_INT3)
          begin
            r_next.int_take = 1'b1;
            r_next.int_type = ccod_pkg::INT_TYPE_BREAK;
            base = ccod_pkg::CYC_INT3;
          end
          else if (i_byte == ccod_pkg::OP_OVF_TRAP)
          begin
            r_next.int_take = i_overflow_flag;
            r_next.int_type = ccod_pkg::INT_TYPE_OVF;
            base = i_overflow_flag ? ccod_pkg::CYC_OVF_TAKEN
                                   : ccod_pkg::CYC_OVF_NOT;
          end
          else if (i_byte == ccod_pkg::OP_HANDLER_RET)
            base = ccod_pkg::CYC_HANDLER_RET;
          else if (i_byte == ccod_pkg::OP_RANGE_CHECK ||
                   i_byte[7:3] == ccod_pkg::OP_HANDOFF_TOP)
            r_next.st = S_MODRM;
          else if (i_byte == ccod_pkg::OP_WAIT)
            r_next.st = S_WAITC;
          else if (i_byte == ccod_pkg::OP_NOP)
            base = ccod_pkg::CYC_NOP;
          else if (i_byte == ccod_pkg::OP_CARRY_INV ||
                   i_byte == ccod_pkg::OP_CARRY_CLR ||
                   i_byte == ccod_pkg::OP_CARRY_SET ||
                   i_byte == ccod_pkg::OP_DIR_CLR ||
                   i_byte == ccod_pkg::OP_DIR_SET ||
                   i_byte == ccod_pkg::OP_IE_CLR ||
                   i_byte == ccod_pkg::OP_IE_SET ||
                   i_byte == ccod_pkg::OP_HALT)
          begin
            base = ccod_pkg::CYC_FLAG;
            if (i_byte == ccod_pkg::OP_CARRY_INV)
              r_next.carry = ~r_reg.carry;
            else if (i_byte == ccod_pkg::OP_CARRY_CLR ||
                     i_byte == ccod_pkg::OP_CARRY_SET)
              r_next.carry = i_byte[0];
            else if (i_byte == ccod_pkg::OP_DIR_CLR ||
                     i_byte == ccod_pkg::OP_DIR_SET)
              r_next.dir = i_byte[0];
            else if (i_byte == ccod_pkg::OP_IE_CLR ||
                     i_byte == ccod_pkg::OP_IE_SET)
              r_next.ie = i_byte[0];
          end
          else
          begin
            // Opcodes outside this block are flagged and drop any prefix.
            r_next.bad = 1'b1;
            r_next.lock = 1'b0;
            r_next.seg_v = 1'b0;
            r_next.st = S_IDLE;
          end
          r_next.cnt = ccod_pkg::cyc_adj(base, i_word_op, i_mem_xfers);
          r_next.cycles = r_next.cnt;
        end
      end
      S_TYPE:
      begin
        if (take)
        begin
          r_next.int_take = 1'b1;
          r_next.int_type = i_byte;
          r_next.cnt = ccod_pkg::cyc_adj(ccod_pkg::CYC_INT_TYPED,
                                         r_reg.word, r_reg.xfers);
          r_next.cycles = r_next.cnt;
          r_next.st = S_EXEC;
        end
      end
      S_MODRM:
      begin
        if (take)
        begin
          r_next.modrm = i_byte;
          r_next.disp = 16'h0000;
          // Displacement bytes come straight after this byte.
          if (mr.disp_bytes == 2'h0)
            fin = 1'b1;
          else
            r_next.st = S_DISP_LO;
        end
      end
      S_DISP_LO:
      begin
        if (take)
        begin
          r_next.disp = {{8{i_byte[7]}}, i_byte};
          if (mr.disp_bytes == 2'h1)
            fin = 1'b1;
          else
            r_next.st = S_DISP_HI;
        end
      end
      S_DISP_HI:
      begin
        if (take)
        begin
          r_next.disp[15:8] = i_byte;
          fin = 1'b1;
        end
      end
      S_WAITC:
      begin
        // Only the second synchroniser stage is consulted.
        if (!r_reg.busy_s2)
        begin
          r_next.cnt = ccod_pkg::CYC_WAIT;
          r_next.cycles = ccod_pkg::CYC_WAIT;
          r_next.st = S_EXEC;
        end
      end
      S_EXEC:
      begin
        if (r_reg.cnt <= 8'h01)
        begin
          r_next.done = 1'b1;
          r_next.st = (r_reg.opcode == ccod_pkg::OP_HALT) ? S_HALTED : S_IDLE;
          r_next.halt = (r_reg.opcode == ccod_pkg::OP_HALT);
          if (!r_reg.prefix)
          begin
            r_next.lock = 1'b0;
            r_next.seg_v = 1'b0;
          end
        end
        else
          r_next.cnt = 8'(r_reg.cnt - 8'h01);
      end
      S_HALTED:
      begin
        if (i_wake)
        begin
          r_next.halt = 1'b0;
          r_next.st = S_IDLE;
        end
      end
    endcase

    // Addressing byte complete: escape and range check finish here.
    if (fin)
    begin
      r_next.st = S_EXEC;
      r_next.direct = mr.direct;
      r_next.reg_sel =
        4'(ccod_pkg::reg_index(r_reg.word, mr.reg_code));
      // Offset calculation is inside the listed figures, so no extra.
      if (r_reg.opcode == ccod_pkg::OP_RANGE_CHECK)
        base = (mr.mode == ccod_pkg::MODE_REG) ? ccod_pkg::CYC_RANGE_MIN
                                               : ccod_pkg::CYC_RANGE_MAX;
      else
      begin
        base = ccod_pkg::CYC_HANDOFF;
        r_next.copro_v = 1'b1;
        r_next.copro_op = {r_reg.opcode[2:0], mr.reg_code};
      end
      r_next.cnt = ccod_pkg::cyc_adj(base, r_reg.word, r_reg.xfers);
      r_next.cycles = r_next.cnt;
      if (i_string_dest)
        r_next.seg_sel = ccod_pkg::SEG_EXTRA;
      else if (r_reg.seg_v)
        r_next.seg_sel = r_reg.seg_ovr;
      else if (mr.uses_frame_base)
        r_next.seg_sel = ccod_pkg::SEG_STACK;
      else
        r_next.seg_sel = ccod_pkg::SEG_DATA;
    end
    r_next.ready = (r_next.st == S_IDLE) || (r_next.st == S_TYPE) ||
                   (r_next.st == S_MODRM) || (r_next.st == S_DISP_LO) ||
                   (r_next.st == S_DISP_HI);
    // Busy is registered so that the port comes straight from a flip-flop.
    r_next.busy = (r_next.st == S_EXEC) || (r_next.st == S_WAITC);
  end

  // State register; all control state is constant under reset.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.ready <= 1'b1;
      r_reg.carry <= ccod_pkg::RST_CARRY;
      r_reg.dir <= ccod_pkg::RST_DIR;
      r_reg.ie <= ccod_pkg::RST_IE;
      r_reg.seg_sel <= ccod_pkg::SEG_DATA;
    end
    else
      r_reg <= r_next;
  end

  // Outputs straight from the state register.
  assign o_byte_ready = r_reg.ready;
  assign o_copro_valid = r_reg.copro_v;
  assign o_copro_opcode = r_reg.copro_op;
  assign o_done = r_reg.done;
  assign o_illegal = r_reg.bad;
  assign o_busy = r_reg.busy;
  assign o_cycles = r_reg.cycles;
  assign o_int_take = r_reg.int_take;
  assign o_int_type = r_reg.int_type;
  assign o_lock = r_reg.lock;
  assign o_halt = r_reg.halt;
  assign o_carry = r_reg.carry;
  assign o_dir = r_reg.dir;
  assign o_ie = r_reg.ie;
  assign o_seg_sel = r_reg.seg_sel;
  assign o_direct = r_reg.direct;
  assign o_operand_offset = r_reg.disp;
  assign o_reg_sel = r_reg.reg_sel;

endmodule // ccod_top

/* File: verif/ccod_copro_model.sv */
// Behavioural coprocessor standing on the escape path of the decoder.
// Assumes the handoff pulse comes from the decoder on the core clock.
`timescale 1ns/100ps
module ccod_copro_model
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Handoff from the decoder and busy span chosen by the bench.
  input wire logic i_handoff,
  input wire logic [7:0] i_hold,
  // Busy level back to the decoder.
  output logic o_copro_busy
);
  logic [7:0] left_reg;

  // Each handed-off opcode keeps the unit busy for i_hold cycles; a zero
  // span models a unit that finishes at once and never looks busy.
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
      left_reg <= 8'h00;
    else if (i_handoff)
      left_reg <= i_hold;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;

  // Driven low whenever no work is pending, so a waiting core proceeds.
  assign o_copro_busy = left_reg != 8'h00;
endmodule // ccod_copro_model

/* File: verif/ccod_top_sva.sv */
// Concurrent checks on the ports of the opcode decoder top.
// Assumes it is bound to ccod_top and sees only its ports.
`timescale 1ns/100ps
module ccod_top_sva
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Byte stream and context.
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic o_byte_ready,
  input wire logic i_word_op,
  input wire logic [1:0] i_mem_xfers,
  input wire logic i_overflow_flag,
  input wire logic i_wake,
  // Results.
  input wire logic o_copro_valid,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic o_busy,
  input wire logic [7:0] o_cycles,
  input wire logic o_int_take,
  input wire logic [7:0] o_int_type,
  input wire logic o_lock,
  input wire logic o_halt,
  input wire logic o_carry,
  input wire logic o_dir,
  input wire logic o_ie
);
  logic fresh_reg;
  logic [7:0] run_reg;
  logic op_take;
  logic pfx;

  // An opcode is taken only when the decoder expects one; this keeps a
  // displacement that looks like an opcode from firing the checks.
  assign op_take = o_byte_ready && i_byte_valid && fresh_reg;
  assign pfx = i_byte == ccod_pkg::OP_LOCK ||
    (i_byte[7:5] == ccod_pkg::OP_SEG_OVR_TOP &&
     i_byte[2:0] == ccod_pkg::OP_SEG_OVR_LOW);

  // Opcode tracking and the length of the current busy run.
  always_ff @(posedge i_clk or posedge i_reset)
    if (i_reset)
    begin
      fresh_reg <= 1'b1;
      run_reg <= 8'h00;
    end
    else
    begin
      if (o_done || o_illegal)
        fresh_reg <= 1'b1;
      else if (o_byte_ready && i_byte_valid && !(fresh_reg && pfx))
        fresh_reg <= 1'b0;
      run_reg <= o_busy ? 8'(run_reg + 8'h01) : 8'h00;
    end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_inv_take;
    op_take && i_byte == ccod_pkg::OP_CARRY_INV;
  endsequence
  sequence s_trap_take;
    op_take && i_byte == ccod_pkg::OP_OVF_TRAP && i_overflow_flag;
  endsequence

  a_done_ready:
    assert property (o_done && !o_halt |-> !o_busy && o_byte_ready)
    else $error("done without ready");
  a_busy_refuse:
    assert property (o_busy || o_halt |-> !o_byte_ready)
    else $error("byte accepted while busy");
  a_done_count:
    assert property (o_done |-> run_reg >= o_cycles && run_reg != 8'h00)
    else $error("done before count ran out");
  a_invert_carry:
    assert property (s_inv_take |=> o_carry == !$past(o_carry))
    else $error("carry not inverted");
  a_flag_cost:
    assert property (s_inv_take |=> o_busy && o_cycles == 8'(8'h02 +
      ($past(i_word_op) ? {4'h0, $past(i_mem_xfers), 2'b00} : 8'h00)))
    else $error("flag op count wrong");
  a_carry_write:
    assert property (op_take && i_byte[7:1] == 7'h7c
      |=> o_carry == $past(i_byte[0]))
    else $error("carry set or clear wrong");
  a_dir_write:
    assert property (op_take && i_byte[7:1] == 7'h7e
      |=> o_dir == $past(i_byte[0]))
    else $error("direction flag wrong");
  a_ie_write:
    assert property (op_take && i_byte[7:1] == 7'h7d
      |=> o_ie == $past(i_byte[0]))
    else $error("interrupt enable wrong");
  a_trap_taken:
    assert property (s_trap_take |-> ##[1:60] o_int_take &&
      o_int_type == ccod_pkg::INT_TYPE_OVF)
    else $error("overflow trap not raised");
  a_trap_quiet:
    assert property (op_take && i_byte == ccod_pkg::OP_OVF_TRAP &&
      !i_overflow_flag |=> !o_int_take [*5])
    else $error("trap raised without overflow");
  a_break_type:
    assert property (op_take && i_byte == ccod_pkg::OP_INT3
      |-> ##[1:50] o_int_take && o_int_type == 8'h03)
    else $error("break interrupt wrong");
  a_handoff_cost:
    assert property (o_copro_valid |-> o_busy && o_cycles[1:0] == 2'h2
      && o_cycles >= 8'h06 ##1 !o_copro_valid)
    else $error("escape handoff wrong");
  a_lock_set:
    assert property (op_take && i_byte == ccod_pkg::OP_LOCK
      |-> ##[1:2] o_lock)
    else $error("lock not raised");
  a_halt_hold:
    assert property (o_halt && !i_wake |=> o_halt)
    else $error("halt left without wake");
endmodule // ccod_top_sva

bind ccod_top ccod_top_sva ccod_top_sva_i (.*);

/* File: verif/tb_top.sv */
// Self-checking bench for the processor-control opcode decoder.
// Assumes the coprocessor model answers on the escape path.
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [7:0] op;
    logic [5:0] cx;
    logic [7:0] cyc;
    logic [2:0] fl;
    logic [8:0] it;
  } ccod_row_t;
  logic i_clk, i_reset, i_byte_valid, i_word_op, i_bus8, i_wake;
  logic i_overflow_flag, i_string_dest, i_copro_busy, seen;
  logic [7:0] i_byte, o_cycles, o_int_type, hold;
  logic [1:0] i_mem_xfers, o_seg_sel;
  logic o_byte_ready, o_copro_valid, o_done, o_illegal, o_busy;
  logic o_int_take, o_lock, o_halt, o_carry, o_dir, o_ie, o_direct;
  logic [5:0] o_copro_opcode, cx;
  logic [15:0] o_operand_offset;
  logic [3:0] o_reg_sel;
  logic [8:0] isee;
  logic [6:0] csee;
  int bad_count, n_compared, took, idle_n;
  // Context cx is {8-bit bus, string dest, overflow, word, transfers}.
  ccod_row_t rows[16] = '{
    '{8'hf9, 6'h00, 8'h02, 3'b100, 9'h000},
    '{8'hf5, 6'h00, 8'h02, 3'b000, 9'h000},
    '{8'hf5, 6'h06, 8'h0a, 3'b100, 9'h000},
    '{8'hf8, 6'h00, 8'h02, 3'b000, 9'h000},
    '{8'hfd, 6'h00, 8'h02, 3'b010, 9'h000},
    '{8'hfc, 6'h00, 8'h02, 3'b000, 9'h000},
    '{8'hfb, 6'h00, 8'h02, 3'b001, 9'h000},
    '{8'hfa, 6'h00, 8'h02, 3'b000, 9'h000},
    '{8'hcc, 6'h00, 8'h2d, 3'b000, 9'h103},
    '{8'hce, 6'h08, 8'h30, 3'b000, 9'h104},
    '{8'hce, 6'h00, 8'h04, 3'b000, 9'h000},
    '{8'hcf, 6'h00, 8'h1c, 3'b000, 9'h000},
    '{8'hcf, 6'h07, 8'h28, 3'b000, 9'h000},
    '{8'hce, 6'h0d, 8'h34, 3'b000, 9'h104},
    '{8'h90, 6'h00, 8'h03, 3'b000, 9'h000},
    '{8'hcf, 6'h20, 8'h1c, 3'b000, 9'h000}};

  ccod_top ccod_top_i (.*);
  ccod_copro_model ccod_copro_model_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_handoff(o_copro_valid), .i_hold(hold), .o_copro_busy(i_copro_busy));

  // Free-running core clock, 50 ns period.
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Edges since the coprocessor last looked busy.
  always @(posedge i_clk)
    idle_n <= i_copro_busy ? 0 : idle_n + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rst;
    chk({o_byte_ready, o_seg_sel, o_busy, o_done, o_carry, o_dir, o_ie,
      o_lock, o_halt, o_cycles}, {3'b111, 15'h0});
  endtask

  // Offers one byte with its context and holds it until the decoder
  // takes it; returns at the taking edge.
  task automatic send(input logic [7:0] b);
    int t;
    t = 0;
    @(posedge i_clk);
    {i_bus8, i_string_dest, i_overflow_flag, i_word_op, i_mem_xfers} <= cx;
    i_byte_valid <= 1'b1;
    i_byte <= b;
    do
    begin
      @(posedge i_clk);
      t++;
    end
    while (o_byte_ready !== 1'b1 && t < 300);
    i_byte_valid <= 1'b0;
  endtask

  // Counts edges from the taking edge to the done pulse.
  task automatic wait_done;
    took = 0;
    isee = 9'h000;
    csee = 7'h00;
    forever
    begin
      #1;
      if (o_int_take === 1'b1)
        isee = {1'b1, o_int_type};
      if (o_copro_valid === 1'b1)
        csee = {1'b1, o_copro_opcode};
      if (o_done === 1'b1 || took > 300)
        break;
      @(posedge i_clk);
      took++;
    end
  endtask

  task automatic op(input logic [31:0] bs, input int nb);
    for (int k = 0; k < nb; k++)
      send(bs[8*k +: 8]);
    wait_done();
  endtask

  task automatic end_sim;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The sequence needs under two thousand cycles; allow eight thousand.
  initial
  begin
    #400000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    {i_reset, i_byte_valid, i_byte, i_wake} = {1'b1, 10'h000};
    {i_bus8, i_string_dest, i_overflow_flag, i_word_op, i_mem_xfers} = 6'h00;
    cx = 6'h00;
    hold = 8'h00;
    repeat (16) @(posedge i_clk);
    chk_rst();
    i_reset <= 1'b0;
    foreach (rows[i])
    begin
      cx = rows[i].cx;
      op({24'h0, rows[i].op}, 1);
      chk(took, rows[i].cyc);
      chk(o_cycles, rows[i].cyc);
      chk({o_carry, o_dir, o_ie}, rows[i].fl);
      chk(isee, rows[i].it);
    end
    cx = 6'h00;
    op({16'h0, 8'h21, 8'hcd}, 2);
    chk({isee, 8'(took)}, {9'h121, 8'd47});
    op({16'h0, 8'hc1, 8'h62}, 2);
    chk(took, 33);
    op({8'h0, 8'h80, 8'h47, 8'h62}, 3);
    chk({o_seg_sel, o_operand_offset}, {2'h3, 16'hff80});
    chk(took, 35);
    op({8'h12, 8'h34, 8'h06, 8'h62}, 4);
    chk({o_direct, o_operand_offset}, 17'h11234);
    // Two-byte displacement on a frame base form.
    op({8'h12, 8'h34, 8'h86, 8'h62}, 4);
    chk({o_direct, o_seg_sel, o_operand_offset}, 19'h21234);
    chk(took, 35);
    for (int s = 0; s < 4; s++)
    begin
      op({8'h05, 8'h46, 8'h62, 3'b001, s[1:0], 3'b110}, 4);
      chk(o_seg_sel, s);
    end
    cx = 6'h10;
    op({8'h0, 8'h05, 8'h62, 8'h3e}, 3);
    chk(o_seg_sel, 0);
    // Escapes with the coprocessor answering at once.
    for (int r = 0; r < 8; r++)
    begin
      cx = {3'b000, r[0], 2'b00};
      op({16'h0, 2'b11, r[2:0], 3'b000, 5'b11011, r[2:0]}, 2);
      chk(took, 6);
      chk(csee, {1'b1, r[2:0], r[2:0]});
      chk(o_reg_sel, {~r[0], r[2:0]});
    end
    cx = 6'h00;
    op({24'h0, 8'h9b}, 1);
    chk(took >= 6 && took <= 10 && o_cycles === 8'h06, 1);
    // A slow coprocessor holds the wait instruction back.
    hold = 8'h14;
    cx = 6'h05;
    op({8'h0, 8'h12, 8'h46, 8'hd9}, 3);
    chk({csee, 8'(took)}, {7'h48, 8'd10});
    chk({o_seg_sel, o_operand_offset}, {2'h2, 16'h0012});
    cx = 6'h00;
    op({24'h0, 8'h9b}, 1);
    chk(idle_n >= 7 && idle_n <= 10 && took > idle_n, 1);
    for (int b = 0; b < 2; b++)
    begin
      cx = {b[0], 5'h00};
      send(8'hf0);
      #1;
      chk({o_lock, o_cycles}, {1'b1, 8'(2 + b)});
      cx = 6'h00;
      op({24'h0, 8'hf8}, 1);
      repeat (2) @(posedge i_clk);
      #1;
      chk({o_lock, 8'(took)}, {1'b0, 8'd2});
    end
    // An unknown opcode drops a pending lock.
    send(8'hf0);
    send(8'h00);
    seen = 1'b0;
    repeat (3)
    begin
      #1;
      seen = seen | (o_illegal === 1'b1);
      @(posedge i_clk);
    end
    #1;
    chk({seen, o_lock}, 2'b10);
    op({24'h0, 8'hf4}, 1);
    repeat (3) @(posedge i_clk);
    i_wake <= 1'b1;
    #1;
    chk({o_halt, o_byte_ready, 8'(took)}, {2'b10, 8'd2});
    @(posedge i_clk);
    i_wake <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk({o_halt, o_byte_ready}, 2'b01);
    // Reset in the middle of an interrupt sequence.
    op({24'h0, 8'hf9}, 1);
    send(8'hcd);
    send(8'h21);
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    #1;
    chk_rst();
    @(posedge i_clk);
    i_reset <= 1'b0;
    op({24'h0, 8'hf5}, 1);
    chk({o_carry, 8'(took)}, {1'b1, 8'd2});
    end_sim();
  end
endmodule // tb_top
